// *** rtl/ebra_core.sv ***
/*
 * External bus cycle sequencer with ready wait states and hold arbitration.
 * Assumes one core clock; ready and hold pins are asynchronous and are
 * synchronised here. Chip select outputs have external pull-ups.
 */
`timescale 1ns/1ps
`include "ebra_map.svh"

module ebra_core
    import ebra_pkg::*;
#(
    parameter int WAIT_W = `EBRA_WAIT_W,
    parameter int CS_W   = `EBRA_CS_W,
    parameter int ADDR_W = `EBRA_ADDR_W,
    parameter int DATA_W = `EBRA_DATA_W
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              cycle_req,
    input  wire logic              cycle_write,
    input  wire logic [ADDR_W-1:0] cycle_addr,
    input  wire logic [DATA_W-1:0] cycle_wdata,
    input  wire logic [CS_W-1:0]   cycle_cs_sel,
    input  wire logic [WAIT_W-1:0] memory_cycle_wait_count,
    input  wire logic              rw_delay_enable,
    input  wire logic              multiplexed_mode,
    input  wire logic              tristate_wait_enable,
    input  wire logic              need_bus,
    input  wire logic              ready_n,
    input  wire logic              hold_n,
    input  wire logic [DATA_W-1:0] data_in,
    output logic                   cycle_ack,
    output logic [DATA_W-1:0]      cycle_rdata,
    output logic                   bus_busy,
    output logic                   clock_output,
    output logic [ADDR_W-1:0]      addr_out,
    output logic                   addr_oe_n,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe_n,
    output logic                   rd_n,
    output logic                   wr_n,
    output logic                   strobe_oe_n,
    output logic [CS_W-1:0]        chip_select_n,
    output logic [CS_W-1:0]        chip_select_oe_n,
    output logic                   hold_grant_n,
    output logic                   bus_request_n
);

    initial begin
        if (WAIT_W < 1 || WAIT_W > 8 || CS_W < 1 || ADDR_W < 1 || DATA_W < 1) begin
            $error("ebra_core parameter out of range");
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic ready_n_s;
    logic hold_n_s;

    ebra_sync #(.STAGES(`EBRA_SYNC_STAGES)) u_ready_sync (
        .clock       (clock),
        .rst         (rst),
        .async_in    (ready_n),
        .reset_value (1'b1),
        .sync_out    (ready_n_s)
    );

    ebra_sync #(.STAGES(`EBRA_SYNC_STAGES)) u_hold_sync (
        .clock       (clock),
        .rst         (rst),
        .async_in    (hold_n),
        .reset_value (1'b1),
        .sync_out    (hold_n_s)
    );

    // ----------------------------------------
    // Clock output and phase
    // ----------------------------------------
    // Sequencer steps once per clock output period, on the rising half
    logic phase_ff;
    logic nxt_phase;
    logic step;

    always_comb begin
        nxt_phase = ~phase_ff;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign step         = phase_ff;
    assign clock_output = phase_ff;

    // ----------------------------------------
    // Cycle sequencer
    // ----------------------------------------
    ebra_state_t             state_ff;
    ebra_state_t             nxt_state;
    logic [WAIT_W-1:0]       wait_ff;
    logic [WAIT_W-1:0]       nxt_wait;
    logic                    write_ff;
    logic                    nxt_write;
    logic [ADDR_W-1:0]       addr_ff;
    logic [ADDR_W-1:0]       nxt_addr;
    logic [DATA_W-1:0]       wdata_ff;
    logic [DATA_W-1:0]       nxt_wdata;
    logic [DATA_W-1:0]       rdata_ff;
    logic [DATA_W-1:0]       nxt_rdata;
    logic [CS_W-1:0]         cs_ff;
    logic [CS_W-1:0]         nxt_cs;
    logic                    ack_ff;
    logic                    nxt_ack;
    logic                    bus_request_n_ff;
    logic                    nxt_bus_request_n;
    logic                    regain_ff;
    logic                    nxt_regain;

    always_comb begin
        nxt_state  = state_ff;
        nxt_wait   = wait_ff;
        nxt_write  = write_ff;
        nxt_addr   = addr_ff;
        nxt_wdata  = wdata_ff;
        nxt_rdata  = rdata_ff;
        nxt_cs     = cs_ff;
        nxt_ack    = 1'b0;
        nxt_bus_request_n   = bus_request_n_ff;
        nxt_regain = 1'b0;
        if (step) begin
            case (state_ff)
                EBRA_IDLE: begin
                    if (!hold_n_s) begin
                        nxt_state = EBRA_HELD;
                    end else if (cycle_req) begin
                        nxt_state = EBRA_ADDR;
                        nxt_write = cycle_write;
                        nxt_addr  = cycle_addr;
                        nxt_wdata = cycle_wdata;
                        nxt_cs    = cycle_cs_sel;
                    end
                end
                EBRA_ADDR: begin
                    nxt_state = rw_delay_enable ? EBRA_RWDLY : EBRA_CMD;
                end
                EBRA_RWDLY: begin
                    nxt_state = EBRA_CMD;
                end
                EBRA_CMD: begin
                    nxt_wait  = memory_cycle_wait_count;
                    nxt_state = (memory_cycle_wait_count != '0) ? EBRA_MCWAIT : EBRA_READY;
                end
                EBRA_MCWAIT: begin
                    nxt_wait = wait_ff - 1'b1;
                    if (wait_ff == {{(WAIT_W-1){1'b0}}, 1'b1}) begin
                        nxt_state = EBRA_READY;
                    end
                end
                EBRA_READY: begin
                    if (!ready_n_s) begin
                        nxt_rdata = write_ff ? rdata_ff : data_in;
                        nxt_ack   = 1'b1;
                        if (multiplexed_mode) begin
                            nxt_state = EBRA_MUXWAIT;
                        end else if (tristate_wait_enable) begin
                            nxt_state = EBRA_TRIWAIT;
                        end else begin
                            nxt_state = EBRA_IDLE;
                        end
                    end
                end
                EBRA_MUXWAIT: begin
                    // Second gap cycle with tristate wait
                    nxt_state = tristate_wait_enable ? EBRA_TRIWAIT : EBRA_IDLE;
                end
                EBRA_TRIWAIT: begin
                    // New cycle only after trailing waits
                    nxt_state = EBRA_IDLE;
                end
                EBRA_HELD: begin
                    nxt_bus_request_n = need_bus ? 1'b1 : bus_request_n_ff;
                    if (hold_n_s) begin
                        nxt_state  = EBRA_IDLE;
                        nxt_bus_request_n   = 1'b0;
                        nxt_regain = 1'b1;
                    end
                end
                default: begin
                    nxt_state = EBRA_IDLE;
                end
            endcase
        end
        if (state_ff != EBRA_HELD) begin
            nxt_bus_request_n = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff  <= EBRA_IDLE;
            wait_ff   <= '0;
            write_ff  <= 1'b0;
            addr_ff   <= '0;
            wdata_ff  <= '0;
            rdata_ff  <= '0;
            cs_ff     <= '0;
            ack_ff    <= 1'b0;
            bus_request_n_ff   <= 1'b0;
            regain_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            wait_ff   <= nxt_wait;
            write_ff  <= nxt_write;
            addr_ff   <= nxt_addr;
            wdata_ff  <= nxt_wdata;
            rdata_ff  <= nxt_rdata;
            cs_ff     <= nxt_cs;
            ack_ff    <= nxt_ack;
            bus_request_n_ff   <= nxt_bus_request_n;
            regain_ff <= nxt_regain;
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    logic in_cycle;
    logic cmd_on;
    logic held;

    assign held     = (state_ff == EBRA_HELD);
    assign in_cycle = (state_ff == EBRA_ADDR) || (state_ff == EBRA_RWDLY) || (state_ff == EBRA_CMD)
                   || (state_ff == EBRA_MCWAIT) || (state_ff == EBRA_READY);
    // Strobe low from command phase on
    assign cmd_on   = (state_ff == EBRA_CMD) || (state_ff == EBRA_MCWAIT) || (state_ff == EBRA_READY);

    assign addr_oe_n   = held;
    assign strobe_oe_n = held;
    assign data_oe_n   = held | ~(in_cycle & write_ff);
    assign addr_out    = addr_ff;
    assign data_out    = wdata_ff;
    assign rd_n        = ~(cmd_on & ~write_ff);
    assign wr_n        = ~(cmd_on & write_ff);

    assign chip_select_oe_n = {CS_W{held}};
    assign chip_select_n    = held ? {CS_W{1'b1}} : ~(cs_ff & {CS_W{in_cycle}});

    // Grant low while held, dropped with regain
    assign hold_grant_n  = ~held;
    assign bus_request_n = ~(bus_request_n_ff & held);

    assign cycle_ack   = ack_ff;
    assign cycle_rdata = rdata_ff;
    assign bus_busy    = (state_ff != EBRA_IDLE);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_bus_request_n_needs_grant;
        @(posedge clock) disable iff (rst) !bus_request_n |-> !hold_grant_n;
    endproperty
    a_bus_request_n_needs_grant: assert property (p_bus_request_n_needs_grant) else $error("bus request without grant");

    property p_grant_floats;
        @(posedge clock) disable iff (rst) !hold_grant_n |-> (addr_oe_n && strobe_oe_n && &chip_select_oe_n);
    endproperty
    a_grant_floats: assert property (p_grant_floats) else $error("bus driven while granted");

    property p_cs_released;
        @(posedge clock) disable iff (rst) !hold_grant_n |-> &chip_select_n;
    endproperty
    a_cs_released: assert property (p_cs_released) else $error("chip select active while released");

    property p_no_grant_mid_cycle;
        @(posedge clock) disable iff (rst) in_cycle |=> hold_grant_n;
    endproperty
    a_no_grant_mid_cycle: assert property (p_no_grant_mid_cycle) else $error("grant during cycle");

    property p_regain_on_hold;
        @(posedge clock) disable iff (rst) $rose(hold_grant_n) |-> $past(hold_n_s);
    endproperty
    a_regain_on_hold: assert property (p_regain_on_hold) else $error("regain without hold release");

    property p_ready_wait;
        @(posedge clock) disable iff (rst) (state_ff == EBRA_READY && step && ready_n_s) |=> state_ff == EBRA_READY;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready high did not wait");

    property p_ready_end;
        @(posedge clock) disable iff (rst) (state_ff == EBRA_READY && step && !ready_n_s) |=> cycle_ack;
    endproperty
    a_ready_end: assert property (p_ready_end) else $error("ready low did not end cycle");

    property p_rw_delay;
        @(posedge clock) disable iff (rst)
            (state_ff == EBRA_ADDR && step && rw_delay_enable) |=> rd_n && wr_n ##2 (state_ff == EBRA_CMD);
    endproperty
    a_rw_delay: assert property (p_rw_delay) else $error("command delay wrong");

    property p_mux_gap;
        @(posedge clock) disable iff (rst)
            (state_ff == EBRA_MUXWAIT && tristate_wait_enable && step) |=> state_ff == EBRA_TRIWAIT [*2];
    endproperty
    a_mux_gap: assert property (p_mux_gap) else $error("tristate wait missing");

    property p_trailing;
        @(posedge clock) disable iff (rst) (state_ff == EBRA_MUXWAIT) |-> chip_select_n == {CS_W{1'b1}};
    endproperty
    a_trailing: assert property (p_trailing) else $error("cycle during trailing wait");

endmodule

// *** rtl/ebra_map.svh ***
/*
 * Constants for the external bus ready and hold arbitration block.
 * Assumes inclusion by its bare name from the package and the modules.
 */
`ifndef EBRA_MAP_SVH
`define EBRA_MAP_SVH

// ----------------------------------------
// Widths and timing
// ----------------------------------------
`define EBRA_WAIT_W        4
`define EBRA_CS_W          5
`define EBRA_ADDR_W        24
`define EBRA_DATA_W        16
`define EBRA_CLK_MHZ       25
// Clock output runs at half the core clock
`define EBRA_CLOCK_OUTPUT_DIV    2
// Gap before the next cycle, mux bus with tristate wait, in clock output cycles
`define EBRA_GAP_MUX_TRI   2
`define EBRA_SYNC_STAGES   2

`endif

// *** rtl/ebra_pkg.sv ***
/*
 * Types for the external bus ready and hold arbitration block.
 * Assumes the constants header sits beside it.
 */
`include "ebra_map.svh"

package ebra_pkg;

    // ----------------------------------------
    // Bus cycle phases, one phase per clock output cycle
    // ----------------------------------------
    typedef enum logic [3:0] {
        EBRA_IDLE    = 4'b0000,
        EBRA_ADDR    = 4'b0001,
        EBRA_RWDLY   = 4'b0010,
        EBRA_CMD     = 4'b0011,
        EBRA_MCWAIT  = 4'b0100,
        EBRA_READY   = 4'b0101,
        EBRA_MUXWAIT = 4'b0110,
        EBRA_TRIWAIT = 4'b0111,
        EBRA_HELD    = 4'b1000
    } ebra_state_t;

endpackage

// *** rtl/ebra_sync.sv ***
/*
 * Multi stage synchroniser for one level.
 * Assumes the input is asynchronous to clock; only the last stage is read.
 */
`timescale 1ns/1ps

module ebra_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic async_in,
    input  wire logic reset_value,
    output logic      sync_out
);
    logic [STAGES-1:0] chain_ff;
    logic [STAGES-1:0] nxt_chain;
    logic [STAGES-1:0] rst_chain;

    initial begin
        if (STAGES < 2) begin
            $error("ebra_sync needs at least two stages");
        end
    end

    always_comb begin
        nxt_chain = {chain_ff[STAGES-2:0], async_in};
    end

    // Reset value is a tie-off constant at the instance
    assign rst_chain = {STAGES{reset_value}};

    always_ff @(posedge clock) begin
        if (rst) begin
            chain_ff <= rst_chain;
        end else begin
            chain_ff <= nxt_chain;
        end
    end

    assign sync_out = chain_ff[STAGES-1];
endmodule

// *** tb/ebra_partner.sv ***
/*
 * Far side model: a memory answering with ready and an external bus master.
 * Assumes resolved command and read strobes from the bench, one clock.
 */
`timescale 1ns/1ps
`include "ebra_map.svh"

module ebra_partner
    import ebra_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    cmd_on,
    input  wire logic                    rd_on,
    input  wire logic [`EBRA_ADDR_W-1:0] addr_out,
    input  wire logic                    ready_stall,
    input  wire logic                    hold_req,
    output logic                         ready_n,
    output logic                         hold_n,
    output logic [`EBRA_DATA_W-1:0]      data_in
);
    initial begin
        ready_n = 1'b1;
        hold_n  = 1'b1;
        data_in = 16'h0000;
    end

    always @(posedge clock) begin
        // Ready only inside a command, withdrawn after it
        ready_n <= !(cmd_on && !ready_stall);
        // Master alone decides when hold ends
        hold_n  <= !hold_req;
        // Undriven data toggles so a stale value is never read back
        data_in <= rd_on ? (addr_out[15:0] ^ 16'h5a5a) : ~data_in;
    end
endmodule

// *** tb/ext_bus_ready_and_hold_arbitration_tb.sv ***
/*
 * Self-checking bench for the ready and hold arbitration sequencer.
 * Assumes ebra_core and the partner model; inputs move on falling edges.
 */
`timescale 1ns/1ps
`include "ebra_map.svh"

module ext_bus_ready_and_hold_arbitration_tb
    import ebra_pkg::*;
;
    logic        clock, rst, cycle_req, cycle_write, rw_delay_enable;
    logic        multiplexed_mode, tristate_wait_enable, need_bus;
    logic        ready_n, hold_n, ready_stall, hold_req;
    logic [23:0] cycle_addr, addr_out;
    logic [15:0] cycle_wdata, data_in, cycle_rdata, data_out;
    logic [4:0]  cycle_cs_sel, chip_select_n, chip_select_oe_n, cs_wire;
    logic [3:0]  memory_cycle_wait_count;
    logic        cycle_ack, bus_busy, clock_output, addr_oe_n, data_oe_n;
    logic        rd_n, wr_n, strobe_oe_n, hold_grant_n, bus_request_n;
    logic        cmd_on, rd_on;
    logic [15:0] seen_wd;
    logic [4:0]  seen_cs;
    int          mismatches, n_checks, b, t_cmd, n, k;
    int          t [2];
    // Delay option in bit 4, programmed waits below
    logic [4:0]  t_tab [6] = '{5'h00, 5'h01, 5'h03, 5'h0f, 5'h10, 5'h12};

    // Released pins rest at the pulled-up level
    assign cs_wire = chip_select_n | chip_select_oe_n;
    assign cmd_on  = !strobe_oe_n && (!rd_n || !wr_n);
    assign rd_on   = !strobe_oe_n && !rd_n;

    ebra_core u_dut (.clock(clock), .rst(rst), .cycle_req(cycle_req), .cycle_write(cycle_write),
        .cycle_addr(cycle_addr), .cycle_wdata(cycle_wdata), .cycle_cs_sel(cycle_cs_sel),
        .memory_cycle_wait_count(memory_cycle_wait_count), .rw_delay_enable(rw_delay_enable),
        .multiplexed_mode(multiplexed_mode), .tristate_wait_enable(tristate_wait_enable),
        .need_bus(need_bus), .ready_n(ready_n), .hold_n(hold_n), .data_in(data_in),
        .cycle_ack(cycle_ack), .cycle_rdata(cycle_rdata), .bus_busy(bus_busy),
        .clock_output(clock_output), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
        .data_out(data_out), .data_oe_n(data_oe_n), .rd_n(rd_n), .wr_n(wr_n),
        .strobe_oe_n(strobe_oe_n), .chip_select_n(chip_select_n),
        .chip_select_oe_n(chip_select_oe_n), .hold_grant_n(hold_grant_n),
        .bus_request_n(bus_request_n));

    ebra_partner u_far (.clock(clock), .cmd_on(cmd_on), .rd_on(rd_on), .addr_out(addr_out),
        .ready_stall(ready_stall), .hold_req(hold_req), .ready_n(ready_n), .hold_n(hold_n),
        .data_in(data_in));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ----------------------------------------
    // Compare, wait and closing tasks
    // ----------------------------------------
    task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        n_checks++;
        if (got != exp) begin
            mismatches++;
            $display("FAIL %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic logic pick(input int w);
        return (w == 0) ? hold_grant_n : (w == 1) ? bus_request_n : cycle_ack;
    endfunction

    // Bounded wait for grant (0), request (1) or ack (2) at a level
    task automatic wait_on(input int w, input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && pick(w) !== lvl; i++)
            @(negedge clock);
        if (pick(w) !== lvl) begin
            mismatches++;
            $display("FAIL wait %0d expected %b seen %b", w, lvl, pick(w));
            close_out();
        end
    endtask

    task automatic start(input logic wr, input logic [23:0] a, input logic [15:0] d);
        cycle_write  = wr;
        cycle_addr   = a;
        cycle_wdata  = d;
        cycle_cs_sel = 5'h01 << a[1:0];
        cycle_req    = 1'b1;
    endtask

    // Counts busy clocks and the clock of the command edge until ack
    task automatic finish;
        int i;
        b     = 0;
        t_cmd = 0;
        for (i = 0; i < 200 && cycle_ack !== 1'b1; i++) begin
            @(negedge clock);
            if (bus_busy === 1'b1)
                b++;
            if (cmd_on && t_cmd == 0) begin
                t_cmd   = b;
                seen_wd = data_out;
                seen_cs = cs_wire;
            end
        end
        cycle_req = 1'b0;
        if (cycle_ack !== 1'b1) begin
            mismatches++;
            $display("FAIL ack expected 1 seen %b", cycle_ack);
            close_out();
        end
        // Idle clock so a following request never lands in this time step
        @(negedge clock);
    endtask

    // Command to command spacing with the request held high
    task automatic gap(input logic mx, input logic tw, input int exp);
        logic prev;
        multiplexed_mode     = mx;
        tristate_wait_enable = tw;
        start(1'b0, 24'h00_0100, 16'h0000);
        k    = 0;
        prev = 1'b0;
        for (int i = 0; i < 100 && !(k == 2 && cycle_ack === 1'b1); i++) begin
            @(negedge clock);
            if (rd_on && !prev && k < 2)
                t[k++] = i;
            prev = rd_on;
        end
        cycle_req = 1'b0;
        if (!(k == 2 && cycle_ack === 1'b1)) begin
            mismatches++;
            $display("FAIL spacing expected 2 commands seen %0d", k);
            close_out();
        end
        chk_cnt("cmd spacing", exp, t[1] - t[0]);
        repeat (8) @(negedge clock);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, cycle_req, cycle_write, rw_delay_enable, multiplexed_mode} = 5'h10;
        {tristate_wait_enable, need_bus, ready_stall, hold_req}         = 4'h0;
        {cycle_addr, cycle_wdata, cycle_cs_sel}                          = '0;
        memory_cycle_wait_count = 4'h0;
        mismatches = 0;
        n_checks   = 0;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        chk_val("grant idle", 24'h00_0001, hold_grant_n);
        chk_val("cs idle", 24'h00_001f, cs_wire);
        chk_val("clock_output low", 24'h00_0000, clock_output);
        @(negedge clock);
        chk_val("clock_output high", 24'h00_0001, clock_output);

        // Cycle length over delay option and programmed waits
        foreach (t_tab[j]) begin
            rw_delay_enable         = t_tab[j][4];
            memory_cycle_wait_count = t_tab[j][3:0];
            start(1'b0, {19'h0, t_tab[j]}, 16'h0000);
            finish();
            chk_cnt("busy clocks", 2 * (3 + t_tab[j][4] + t_tab[j][3:0]), b);
            chk_cnt("cmd clock", 2 * (1 + t_tab[j][4]) + 1, t_cmd);
            chk_val("rdata", {8'h0, 16'h5a5a ^ {11'h0, t_tab[j]}}, cycle_rdata);
            @(negedge clock);
        end
        rw_delay_enable         = 1'b0;
        memory_cycle_wait_count = 4'h0;

        start(1'b1, 24'h12_3402, 16'hbeef);
        finish();
        chk_val("wdata", 24'h00_beef, seen_wd);
        chk_val("cs sel", 24'h00_001b, seen_cs);

        // Ready held high stretches the cycle
        ready_stall = 1'b1;
        start(1'b0, 24'h00_0040, 16'h0000);
        repeat (40) @(negedge clock);
        chk_val("busy stalled", 24'h00_0001, bus_busy);
        ready_stall = 1'b0;
        finish();
        chk_val("rdata late", 24'h00_5a1a, cycle_rdata);

        gap(1'b0, 1'b0, 8);
        gap(1'b1, 1'b0, 10);
        gap(1'b0, 1'b1, 10);
        gap(1'b1, 1'b1, 12);
        multiplexed_mode     = 1'b0;
        tristate_wait_enable = 1'b0;

        // Hold during a running cycle, then device asks back
        ready_stall = 1'b1;
        need_bus    = 1'b1;
        start(1'b0, 24'h00_0080, 16'h0000);
        repeat (6) @(negedge clock);
        hold_req = 1'b1;
        repeat (20) @(negedge clock);
        chk_val("grant in cycle", 24'h00_0001, hold_grant_n);
        chk_val("req before grant", 24'h00_0001, bus_request_n);
        ready_stall = 1'b0;
        finish();
        wait_on(0, 1'b0, 20);
        chk_val("cs released", 24'h00_001f, cs_wire);
        chk_val("oe released", 24'h00_003f,
                {addr_oe_n, data_oe_n, strobe_oe_n, chip_select_oe_n[2:0]});
        wait_on(1, 1'b0, 8);
        cycle_req = 1'b1;
        repeat (20) @(negedge clock);
        chk_val("still held", 24'h00_0001, !hold_grant_n);
        chk_val("busy while held", 24'h00_0001, bus_busy);
        chk_val("refused in hold", 24'h00_0003, {rd_n, wr_n});
        cycle_req = 1'b0;
        hold_req  = 1'b0;
        wait_on(0, 1'b1, 12);
        chk_val("req cleared", 24'h00_0001, bus_request_n);
        chk_val("bus driven", 24'h00_0000, {addr_oe_n, strobe_oe_n});
        repeat (10) @(negedge clock);
        chk_val("late req", 24'h00_0001, bus_request_n);

        // Master gives the bus back unasked
        need_bus = 1'b0;
        hold_req = 1'b1;
        wait_on(0, 1'b0, 20);
        repeat (10) @(negedge clock);
        chk_val("no req unasked", 24'h00_0001, bus_request_n);
        hold_req = 1'b0;
        wait_on(0, 1'b1, 12);
        start(1'b0, 24'h00_0003, 16'h0000);
        finish();
        chk_val("after regain", 24'h00_5a59, cycle_rdata);
        close_out();
    end
endmodule
